// file: eflc_consts.vh
/*
 Constants for the embedded flash lock, security and boot controller.
 Assumes inclusion by the controller and its write buffer, by bare name.
*/
`ifndef EFLC_CONSTS_VH
`define EFLC_CONSTS_VH

// Geometry
`define EFLC_PAGE_BYTES 256
`define EFLC_PAGES_PER_REGION 32
`define EFLC_REGION_BYTES 8192
`define EFLC_LOCK_BITS 16
`define EFLC_LOCK_BITS_SMALL 8
`define EFLC_PAGE_W 10
`define EFLC_WBUF_BYTES 128
`define EFLC_WBUF_WORDS 32
`define EFLC_WBUF_AW 5

// Register byte offsets
`define EFLC_OFF_MODE 12'h000
`define EFLC_OFF_CMD 12'h004
`define EFLC_OFF_STATUS 12'h008
`define EFLC_OFF_RESULT 12'h00C
`define EFLC_OFF_LOCKS 12'h010
`define EFLC_OFF_NVBITS 12'h014
`define EFLC_OFF_UID0 12'h020
`define EFLC_OFF_WBUF 12'h200
`define EFLC_OFF_ROMBASE 12'h018

// Command register layout: key[31:24], arg[23:8], opcode[7:0]
`define EFLC_CMD_KEY 8'h5A
`define EFLC_CMD_KEY_HI 31
`define EFLC_CMD_KEY_LO 24
`define EFLC_CMD_ARG_HI 23
`define EFLC_CMD_ARG_LO 8

// Command opcodes
`define EFLC_OP_DESC 8'h00
`define EFLC_OP_PROG 8'h01
`define EFLC_OP_ERASE_PAGE 8'h02
`define EFLC_OP_ERASE_ALL 8'h05
`define EFLC_OP_SET_LOCK 8'h08
`define EFLC_OP_CLR_LOCK 8'h09
`define EFLC_OP_SET_NV 8'h0B
`define EFLC_OP_CLR_NV 8'h0C

// Status bits
`define EFLC_ST_READY 0
`define EFLC_ST_CMDERR 1
`define EFLC_ST_LOCKERR 2

// Mode bit: read width select, 0 = 128-bit, 1 = 64-bit
`define EFLC_MODE_W64 0

// Nonvolatile bit positions
`define EFLC_NV_SECURE 0
`define EFLC_NV_BOOTSRC 1
`define EFLC_NV_BOOTBANK 2

// Memory map
`define EFLC_ROM_BASE 32'h00180000
`define EFLC_BOOT_ADDR 32'h00000000

// AXI responses
`define EFLC_RESP_OKAY 2'h0
`define EFLC_RESP_SLVERR 2'h2

// Cycles a flash operation occupies the array: one per buffered word
`define EFLC_OP_CYCLES 16'h0020
`endif

// file: eflc_wbuf.v
/*
 Page write buffer: 32 words of 32 bits, filled a word at a time.
 Assumes the controller gates writes and reads it out while programming.
*/
`include "eflc_consts.vh"

module eflc_wbuf (
	input wire aclk,
	input wire aresetn,
	input wire wr_en,
	input wire [`EFLC_WBUF_AW-1:0] wr_idx,
	input wire [31:0] wr_data,
	input wire [3:0] wr_strb,
	input wire [`EFLC_WBUF_AW-1:0] rd_idx,
	output reg [31:0] rd_data
);
	reg [31:0] mem [0:`EFLC_WBUF_WORDS-1];
	integer b;

	always @(posedge aclk) begin
		if (wr_en) begin
			for (b = 0; b < 4; b = b + 1) begin
				if (wr_strb[b])
					mem[wr_idx][b*8 +: 8] <= wr_data[b*8 +: 8];
			end
		end
		if (!aresetn)
			rd_data <= 32'h00000000;
		else
			rd_data <= mem[rd_idx];
	end
endmodule

// file: eflc_ctrl.v
/*
 Embedded flash lock, security and boot controller with AXI4-Lite registers.
 Assumes synchronous inputs on aclk, a flash array taking one word per cycle
 with no handshake back, and a wipe pin already debounced by the system.
*/
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
// Operation
// R1: 256-byte pages, 32-page 8 KB lock regions
// R2: Sixteen lock bits, eight on small variant
// R3: Locked program or erase aborts, raises interrupt
// R4: Set-lock and clear-lock commands change lock bit
// R5: Wipe pin clears every lock bit
// R6: Secure bit blocks debug and fast-port access
// R7: Secure set only; cleared by wipe plus erase
// R8: Wipe pin held beyond 200 ms externally
// R9: 128-bit unique id, calibration bits read-only
// R10: Three nonvolatile bits with set, clear commands
// R11: Secondary controller has no nonvolatile bits
// R12: Boot always fetches from address zero
// R13: Boot-source bit set means flash boot
// R14: Wipe pin clears the boot-source bit
// R15: Boot-bank bit picks second block when set
// R16: ROM always visible at fixed base
// R17: 128-byte write buffer, 32-bit fill interface
// R18: Read width selectable, 128 or 64 bits
// R19: Descriptor command reports flash geometry
// R20: Programmer straps pins high at power-up
// R21: Fast port accepts read, program, erase, lock commands
// R22: Busy while running; early command flags error
`include "eflc_consts.vh"

module eflc_ctrl #(
	parameter IS_PRIMARY = 1,
	parameter SMALL_VARIANT = 0,
	parameter [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0011223344556677, // Arbitrary value
	parameter [15:0] CALIB_BITS = 16'hA5A5
) (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire wipe_pin,
	input wire debug_req,
	input wire fast_port_req,
	output reg debug_grant_q,
	output reg fast_port_grant_q,
	output reg flash_irq_q,
	output reg busy_q,
	output reg read_wide_q,
	output reg boot_from_flash_q,
	output reg boot_bank_q,
	output reg [31:0] boot_map_base_q,
	output reg [31:0] rom_base_q,
	output reg flash_op_q,
	output reg [7:0] flash_opcode_q,
	output reg [`EFLC_PAGE_W-1:0] flash_page_q,
	output reg [31:0] flash_wdata_q
);
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN = 2'd1;
	localparam ST_WIPE = 2'd2;

	reg [1:0] state_q;
	reg [15:0] count_q;
	reg [15:0] lock_q;
	reg [2:0] nv_q;
	reg cmd_err_q;
	reg lock_err_q;
	reg [31:0] result_q;
	reg [7:0] op_q;
	reg [15:0] arg_q;
	reg wipe_seen_q;
	reg [11:0] awaddr_q;
	reg aw_have_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg w_have_q;
	reg [`EFLC_WBUF_AW-1:0] rd_idx_q;
	wire [31:0] wbuf_rdata;

	// Lock region of a page: 32 pages per region
	function [3:0] region_of;
		input [15:0] page;
		begin
			region_of = page[8:5]; // [R1]
		end
	endfunction

	function region_locked;
		input [15:0] page;
		input [15:0] locks;
		reg [3:0] r;
		begin
			r = region_of(page);
			if (SMALL_VARIANT != 0 && r[3])
				region_locked = 1'b0;
			else
				region_locked = locks[r];
		end
	endfunction

	wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
	wire wr_cmd = do_write && awaddr_q == `EFLC_OFF_CMD;
	wire wr_wbuf = do_write && awaddr_q >= `EFLC_OFF_WBUF &&
		awaddr_q < `EFLC_OFF_WBUF + 12'd128;
	wire key_ok = wdata_q[`EFLC_CMD_KEY_HI:`EFLC_CMD_KEY_LO] == `EFLC_CMD_KEY;
	wire [7:0] new_op = wdata_q[7:0];
	wire [15:0] new_arg = wdata_q[`EFLC_CMD_ARG_HI:`EFLC_CMD_ARG_LO];

	eflc_wbuf u_wbuf (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(wr_wbuf && state_q == ST_IDLE), // [R17]
		.wr_idx(awaddr_q[6:2]),
		.wr_data(wdata_q),
		.wr_strb(wstrb_q),
		.rd_idx(rd_idx_q),
		.rd_data(wbuf_rdata)
	);

	// AXI write address and data, taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `EFLC_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_q == `EFLC_OFF_CMD || awaddr_q == `EFLC_OFF_MODE || wr_wbuf)
					s_axi_bresp <= `EFLC_RESP_OKAY;
				else
					s_axi_bresp <= `EFLC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `EFLC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `EFLC_RESP_OKAY;
				if (s_axi_araddr[11:2] == `EFLC_OFF_MODE >> 2)
					s_axi_rdata <= {31'h0, ~read_wide_q}; // [R18]
				else if (s_axi_araddr[11:2] == `EFLC_OFF_STATUS >> 2)
					s_axi_rdata <= {29'h0, lock_err_q, cmd_err_q, ~busy_q}; // [R22]
				else if (s_axi_araddr[11:2] == `EFLC_OFF_RESULT >> 2)
					s_axi_rdata <= result_q;
				else if (s_axi_araddr[11:2] == `EFLC_OFF_LOCKS >> 2)
					s_axi_rdata <= {16'h0, lock_q};
				else if (s_axi_araddr[11:2] == `EFLC_OFF_NVBITS >> 2)
					s_axi_rdata <= {13'h0, CALIB_BITS, nv_q}; // [R9]
				else if (s_axi_araddr[11:2] == `EFLC_OFF_ROMBASE >> 2)
					s_axi_rdata <= rom_base_q;
				else if (s_axi_araddr[11:4] == `EFLC_OFF_UID0 >> 4)
					s_axi_rdata <= UNIQUE_ID[s_axi_araddr[3:2]*32 +: 32]; // [R9]
				else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `EFLC_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Command sequencer, locks and nonvolatile bits
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			count_q <= 16'h0000;
			lock_q <= 16'h0000;
			nv_q <= 3'b000;
			cmd_err_q <= 1'b0;
			lock_err_q <= 1'b0;
			result_q <= 32'h00000000;
			op_q <= 8'h00;
			arg_q <= 16'h0000;
			wipe_seen_q <= 1'b0;
			busy_q <= 1'b0;
			flash_irq_q <= 1'b0;
			read_wide_q <= 1'b1;
			flash_op_q <= 1'b0;
			flash_opcode_q <= 8'h00;
			flash_page_q <= {`EFLC_PAGE_W{1'b0}};
			flash_wdata_q <= 32'h00000000;
			rd_idx_q <= {`EFLC_WBUF_AW{1'b0}};
		end else begin
			flash_op_q <= 1'b0;
			flash_irq_q <= 1'b0;
			if (do_write && awaddr_q == `EFLC_OFF_MODE && wstrb_q[0])
				read_wide_q <= !wdata_q[`EFLC_MODE_W64]; // [R18]
			case (state_q)
			ST_IDLE: begin
				if (wipe_pin) begin
					lock_q <= 16'h0000; // [R5]
					nv_q[`EFLC_NV_BOOTSRC] <= 1'b0; // [R14]
					wipe_seen_q <= 1'b1;
					state_q <= ST_WIPE;
					busy_q <= 1'b1;
					count_q <= 16'h0000;
				end else if (wr_cmd && key_ok) begin
					op_q <= new_op;
					arg_q <= new_arg;
					cmd_err_q <= 1'b0;
					lock_err_q <= 1'b0;
					if ((new_op == `EFLC_OP_PROG || new_op == `EFLC_OP_ERASE_PAGE) &&
						region_locked(new_arg, lock_q)) begin
						lock_err_q <= 1'b1; // [R3]
						flash_irq_q <= 1'b1; // [R3]
					end else if ((new_op == `EFLC_OP_SET_LOCK || new_op == `EFLC_OP_CLR_LOCK) &&
						SMALL_VARIANT != 0 && region_of(new_arg) >= `EFLC_LOCK_BITS_SMALL) begin
						cmd_err_q <= 1'b1; // [R2]
					end else if (new_op == `EFLC_OP_SET_LOCK) begin
						lock_q[region_of(new_arg)] <= 1'b1; // [R4] [R2]
					end else if (new_op == `EFLC_OP_CLR_LOCK) begin
						lock_q[region_of(new_arg)] <= 1'b0; // [R4]
					end else if ((new_op == `EFLC_OP_SET_NV || new_op == `EFLC_OP_CLR_NV) &&
						(IS_PRIMARY == 0 || new_arg > 16'd2)) begin
						cmd_err_q <= 1'b1; // [R11]
					end else if (new_op == `EFLC_OP_SET_NV) begin
						nv_q[new_arg[1:0]] <= 1'b1; // [R10]
					end else if (new_op == `EFLC_OP_CLR_NV) begin
						if (new_arg[1:0] != `EFLC_NV_SECURE)
							nv_q[new_arg[1:0]] <= 1'b0; // [R10]
						else
							cmd_err_q <= 1'b1; // [R7]
					end else if (new_op == `EFLC_OP_DESC) begin
						result_q <= {5'd0, 11'd`EFLC_PAGE_BYTES, 6'd`EFLC_PAGES_PER_REGION,
							SMALL_VARIANT ? 5'd`EFLC_LOCK_BITS_SMALL : 5'd`EFLC_LOCK_BITS, 5'd0}; // [R19] [R1]
					end else if (new_op == `EFLC_OP_PROG || new_op == `EFLC_OP_ERASE_PAGE ||
						new_op == `EFLC_OP_ERASE_ALL) begin
						state_q <= ST_RUN;
						busy_q <= 1'b1; // [R22]
						count_q <= 16'h0000;
						// Buffer read runs one word ahead of the array
						rd_idx_q <= {{(`EFLC_WBUF_AW-1){1'b0}}, 1'b1};
					end else begin
						cmd_err_q <= 1'b1;
					end
				end
			end
			ST_RUN: begin
				if (wr_cmd)
					cmd_err_q <= 1'b1; // [R22]
				count_q <= count_q + 16'h0001;
				// Busy falls on the edge that ends the last array cycle, together with flash_op_q
				if (count_q == `EFLC_OP_CYCLES) begin
					state_q <= ST_IDLE;
					busy_q <= 1'b0;
					rd_idx_q <= {`EFLC_WBUF_AW{1'b0}};
					if (op_q == `EFLC_OP_ERASE_ALL && wipe_seen_q) begin
						nv_q[`EFLC_NV_SECURE] <= 1'b0; // [R7]
						wipe_seen_q <= 1'b0;
					end
				end else begin
					flash_op_q <= 1'b1;
					flash_opcode_q <= op_q;
					flash_page_q <= arg_q[`EFLC_PAGE_W-1:0];
					flash_wdata_q <= wbuf_rdata; // [R17]
					rd_idx_q <= rd_idx_q + 1'b1;
				end
			end
			default: begin
				// Wipe: clear protection, then a full array erase
				if (wr_cmd)
					cmd_err_q <= 1'b1; // [R22]
				if (!wipe_pin) begin
					op_q <= `EFLC_OP_ERASE_ALL;
					arg_q <= 16'h0000;
					count_q <= 16'h0000;
					state_q <= ST_RUN; // [R7]
				end
			end
			endcase
		end
	end

	// Boot map, ROM alias and port gating
	always @(posedge aclk) begin
		if (!aresetn) begin
			boot_from_flash_q <= 1'b0;
			boot_bank_q <= 1'b0;
			boot_map_base_q <= `EFLC_ROM_BASE;
			rom_base_q <= `EFLC_ROM_BASE;
			debug_grant_q <= 1'b0;
			fast_port_grant_q <= 1'b0;
		end else begin
			boot_from_flash_q <= nv_q[`EFLC_NV_BOOTSRC]; // [R13]
			boot_bank_q <= nv_q[`EFLC_NV_BOOTBANK]; // [R15]
			// Memory aliased at the boot address
			if (!nv_q[`EFLC_NV_BOOTSRC])
				boot_map_base_q <= `EFLC_ROM_BASE; // [R12] [R13]
			else
				boot_map_base_q <= `EFLC_BOOT_ADDR; // [R12]
			rom_base_q <= `EFLC_ROM_BASE; // [R16]
			debug_grant_q <= debug_req && !nv_q[`EFLC_NV_SECURE]; // [R6]
			fast_port_grant_q <= fast_port_req && !nv_q[`EFLC_NV_SECURE]; // [R6] [R21]
		end
	end
endmodule

// file: eflc_flash_model.sv
/*
 Flash array stand-in: records each operation the controller launches.
 Assumes flash_op_q is held high for the whole of one operation.
*/
`include "eflc_consts.vh"

module eflc_flash_model (
	input wire logic aclk,
	input wire logic flash_op_q,
	input wire logic [7:0] flash_opcode_q,
	input wire logic [`EFLC_PAGE_W-1:0] flash_page_q,
	input wire logic [31:0] flash_wdata_q,
	output int op_count,
	output logic [7:0] last_op,
	output logic [`EFLC_PAGE_W-1:0] last_page,
	output logic [31:0] first_wdata,
	output logic [31:0] last_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev_q = 1'b0;
	initial op_count = 0;
	always @(posedge aclk) begin
		prev_q <= flash_op_q;
		if (flash_op_q)
			last_wdata <= flash_wdata_q;
		if (flash_op_q && !prev_q) begin
			op_count <= op_count + 1;
			last_op <= flash_opcode_q;
			last_page <= flash_page_q;
			first_wdata <= flash_wdata_q;
		end
	end
endmodule

// file: eflc_ctrl_chk.sv
/*
 Port checker for the flash lock, security and boot controller.
 Assumes a bind onto eflc_ctrl, one clock aclk, sync active-low aresetn.
*/
module eflc_ctrl_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic debug_req,
	input wire logic fast_port_req,
	input wire logic debug_grant_q,
	input wire logic fast_port_grant_q,
	input wire logic flash_irq_q,
	input wire logic busy_q,
	input wire logic flash_op_q,
	input wire logic boot_from_flash_q,
	input wire logic [31:0] boot_map_base_q,
	input wire logic [31:0] rom_base_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_rom_fixed: assert property (rom_base_q == 32'h00180000)
		else $error("rom base moved");
	chk_boot_map: assert property (boot_map_base_q == (boot_from_flash_q ? 32'h0 : 32'h00180000))
		else $error("boot map wrong");
	chk_debug_gate: assert property (debug_grant_q |-> $past(debug_req))
		else $error("debug grant without request");
	chk_fast_gate: assert property (fast_port_grant_q |-> $past(fast_port_req))
		else $error("fast port grant without request");
	chk_op_busy: assert property (flash_op_q |-> busy_q)
		else $error("flash op while not busy");
	chk_irq_pulse: assert property (flash_irq_q |=> !flash_irq_q && !flash_op_q)
		else $error("irq not a pulse or flash touched");
	chk_op_length: assert property ($rose(flash_op_q) |-> ##31 flash_op_q ##1 !flash_op_q)
		else $error("flash op length wrong");
	chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");

	cov_irq: cover property (flash_irq_q);
	cov_op: cover property ($rose(flash_op_q));
	cov_grant: cover property (debug_grant_q);
endmodule

bind eflc_ctrl eflc_ctrl_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
	.debug_req, .fast_port_req, .debug_grant_q, .fast_port_grant_q, .flash_irq_q, .busy_q, .flash_op_q,
	.boot_from_flash_q, .boot_map_base_q, .rom_base_q);

// file: tb_top.sv
/*
 Testbench for eflc_ctrl: register tasks over AXI4-Lite and command tests.
 Assumes the flash model stands on the array side.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, wipe_pin = 0, debug_req = 0, fast_port_req = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, boot_map_base_q, rom_base_q, flash_wdata_q, rd_v;
	logic debug_grant_q, fast_port_grant_q, flash_irq_q, busy_q, read_wide_q, boot_from_flash_q, boot_bank_q;
	logic flash_op_q;
	logic [7:0] flash_opcode_q, last_op;
	logic [9:0] flash_page_q, last_page;
	logic [31:0] first_wdata, last_wdata;
	int n_errors = 0, check_count = 0, irq_n = 0, op_count, k;

	always #25 aclk = ~aclk;
	always @(posedge aclk) if (flash_irq_q) irq_n++;

	eflc_ctrl DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wipe_pin, .debug_req,
		.fast_port_req, .debug_grant_q, .fast_port_grant_q, .flash_irq_q, .busy_q, .read_wide_q,
		.boot_from_flash_q, .boot_bank_q, .boot_map_base_q, .rom_base_q, .flash_op_q, .flash_opcode_q,
		.flash_page_q, .flash_wdata_q);
	eflc_flash_model u_flash (.aclk, .flash_op_q, .flash_opcode_q, .flash_page_q, .flash_wdata_q, .op_count,
		.last_op, .last_page, .first_wdata, .last_wdata);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd_v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
		axi_wr(12'h004, {8'h5A, arg, op});
		repeat (2) @(posedge aclk);
		while (busy_q) @(posedge aclk);
	endtask

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(read_wide_q, 1'b1);
		check(boot_map_base_q, 32'h00180000);
		axi_rd(12'h018);
		check(rd_v, 32'h00180000);
		axi_rd(12'h100);
		check(rsp, 2'h2);
		axi_wr(12'h000, 32'h1);
		check(read_wide_q, 1'b0);
		cmd(8'h00, 16'h0000);
		axi_rd(12'h00C);
		check(rd_v, 32'h01008200);
		axi_rd(12'h020);
		check(rd_v, 32'h44556677);
		axi_wr(12'h020, 32'h0);
		check(rsp, 2'h2);
		$display("test reset_mode done");
		cmd(8'h08, 16'h0020);
		cmd(8'h08, 16'h01E0);
		axi_rd(12'h010);
		check(rd_v, 32'h8002);
		k = op_count;
		cmd(8'h01, 16'h0021);
		check(irq_n, 1);
		check(op_count, k);
		axi_rd(12'h008);
		check(rd_v[2], 1'b1);
		axi_wr(12'h200, 32'h11223344);
		check(rsp, 2'h0);
		axi_wr(12'h27C, 32'h55667788);
		cmd(8'h01, 16'h0040);
		check({last_op, 6'h0, last_page}, {8'h01, 6'h0, 10'h040});
		check(first_wdata, 32'h11223344);
		check(last_wdata, 32'h55667788);
		cmd(8'h09, 16'h003F);
		axi_rd(12'h010);
		check(rd_v, 32'h8000);
		axi_wr(12'h004, {8'h5A, 16'h0041, 8'h02});
		check(busy_q, 1'b1);
		cmd(8'h02, 16'h0042);
		axi_rd(12'h008);
		check(rd_v[1], 1'b1);
		check(op_count, k + 2);
		$display("test locks done");
		cmd(8'h0B, 16'h1);
		cmd(8'h0B, 16'h2);
		check({30'h0, boot_from_flash_q, boot_bank_q}, 32'h3);
		check(boot_map_base_q, 32'h0);
		cmd(8'h0B, 16'h0);
		debug_req <= 1'b1;
		fast_port_req <= 1'b1;
		repeat (3) @(posedge aclk);
		check({debug_grant_q, fast_port_grant_q}, 2'b00);
		axi_rd(12'h014);
		check(rd_v[2:0], 3'h7);
		cmd(8'h0C, 16'h0);
		axi_rd(12'h008);
		check(rd_v[1], 1'b1);
		cmd(8'h0C, 16'h2);
		check(boot_bank_q, 1'b0);
		$display("test nvbits done");
		wipe_pin <= 1'b1;
		repeat (40) @(posedge aclk);
		wipe_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		while (busy_q) @(posedge aclk);
		axi_rd(12'h010);
		check(rd_v, 32'h0);
		axi_rd(12'h014);
		check(rd_v, {13'h0, 16'hA5A5, 3'h0});
		axi_rd(12'h020);
		check(rd_v, 32'h44556677);
		repeat (2) @(posedge aclk);
		check({debug_grant_q, fast_port_grant_q, last_op}, {2'b11, 8'h05});
		$display("test wipe done");
		end_of_test;
	end

	initial begin
		repeat (5000) @(posedge aclk);
		n_errors++;
		end_of_test;
	end
endmodule
